// >>> rtl/ecgc_pkg.sv
// Constants, field layout and types for the electrode channel control register block.
// What this block does
// - Serial word: bit 31 read/write, bits 30-24 address, bits 23-0 data, MSB first.
// - Channel control register lives at address 0x01 and resets to all zeros.
// - Bits 23-19 enable one electrode channel each; zero powers down, input high-impedance.
// - Bit 10 picks the input type: 0 single-ended, 1 differential.
// - Bits 9-8 set front-end gain: 00 x1.4, 01 x2.1, 10 x2.8.
package ecgc_pkg;

   // Serial word layout.
   localparam int unsigned ECGC_WORD_BITS = 32;
   localparam int unsigned ECGC_HEAD_BITS = 8;
   localparam int unsigned ECGC_DATA_BITS = 24;
   localparam int unsigned ECGC_ADDR_BITS = 7;
   localparam logic [5:0] ECGC_HEAD_LAST = 6'h07;
   localparam logic [5:0] ECGC_WORD_LAST = 6'h1f;
   localparam logic ECGC_RW_WRITE = 1'h1;

   // Register map.
   localparam logic [6:0] ECGC_ADDR_CTL = 7'h01;
   localparam logic [23:0] ECGC_CTL_RESET = 24'h000000;

   // Field positions inside the 24 data bits.
   localparam int unsigned ECGC_EN_HI = 23;
   localparam int unsigned ECGC_EN_LO = 19;
   localparam int unsigned ECGC_DIFF_BIT = 10;
   localparam int unsigned ECGC_GAIN_HI = 9;
   localparam int unsigned ECGC_GAIN_LO = 8;
   localparam int unsigned ECGC_CHANNELS = 5;

   // Gain codes.
   localparam logic [1:0] ECGC_GAIN_X1P4 = 2'h0;
   localparam logic [1:0] ECGC_GAIN_X2P1 = 2'h1;
   localparam logic [1:0] ECGC_GAIN_X2P8 = 2'h2;
   localparam logic [1:0] ECGC_GAIN_X4P2 = 2'h3;

   // Synchroniser depth for pin inputs.
   localparam int unsigned ECGC_SYNC_STAGES = 2;

   // Control fields in bit order 23..19, then 10, then 9..8.
   typedef struct packed {
      logic left_arm_channel_enable;
      logic left_leg_channel_enable;
      logic right_arm_channel_enable;
      logic chest_one_channel_enable;
      logic chest_two_channel_enable;
      logic differential_input_select;
      logic [1:0] gain_code;
   } ecgc_ctrl_t;

   // Serial pins as seen by the device.
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic sdi;
   } ecgc_pins_t;

   typedef enum logic [1:0] {
      ECGC_IDLE = 2'b00,
      ECGC_HEAD = 2'b01,
      ECGC_DATA = 2'b10,
      ECGC_DONE = 2'b11
   } ecgc_state_t;

   localparam ecgc_ctrl_t ECGC_CTRL_RESET = '0;

endpackage

// >>> rtl/ecgc_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module ecgc_sync #(
   parameter int unsigned WIDTH = 3
) (
   input wire logic clk, // System clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic [WIDTH-1:0] async_in, // Raw pin levels.
   input wire logic [WIDTH-1:0] reset_level, // Level held during reset.
   output logic [WIDTH-1:0] sync_out // Levels after two flops.
);
   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second; nothing else may look at it.
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= reset_level;
         sync_out <= reset_level;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// >>> rtl/ecgc_top.sv
// Serial slave and electrode channel control register with its decoded front-end controls.
`timescale 1ns/1ps
module ecgc_top (
   input wire logic clk, // 20 MHz system clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic sclk, // Serial clock pin from the host.
   input wire logic cs_n, // Serial select pin, active low.
   input wire logic sdi, // Serial data in from the host.
   output logic sdo, // Serial data out to the host.
   output logic sdo_oe, // High while the device drives sdo.
   output logic [4:0] channel_enable, // Per-channel power enable, bit 4 is left arm.
   output logic [4:0] input_high_z, // Per-channel input high-impedance request.
   output logic differential_input_select, // 1 selects differential front-end inputs.
   output logic [1:0] gain_code, // Preamplifier and filter gain code.
   output logic ctl_written // One-cycle pulse after the register is updated.
);
   import ecgc_pkg::*;

   ecgc_pins_t pins_raw;
   ecgc_pins_t pins_s;
   ecgc_pins_t pins_rst;
   logic sclk_q;
   ecgc_state_t state;
   ecgc_state_t next_state;
   logic [31:0] shreg;
   logic [31:0] next_shreg;
   logic [5:0] bit_cnt;
   logic [5:0] next_bit_cnt;
   logic [23:0] out_shreg;
   logic [23:0] next_out_shreg;
   logic rw_flag;
   logic next_rw_flag;
   ecgc_ctrl_t ctl;
   ecgc_ctrl_t next_ctl;
   logic next_sdo;
   logic next_sdo_oe;
   logic next_ctl_written;

   assign pins_raw = '{sclk: sclk, cs_n: cs_n, sdi: sdi};
   assign pins_rst = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};

   // Pins are asynchronous to clk, so everything below reads the synchronised copies.
   ecgc_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in(pins_raw),
      .reset_level(pins_rst),
      .sync_out(pins_s)
   );

   // Edge detection on the synchronised serial clock.
   wire sclk_rise = pins_s.sclk & ~sclk_q;
   wire sclk_fall = ~pins_s.sclk & sclk_q;
   wire selected = ~pins_s.cs_n;

   wire [31:0] shreg_shifted = {shreg[30:0], pins_s.sdi};
   wire head_done = sclk_rise && (state == ECGC_HEAD) && (bit_cnt == ECGC_HEAD_LAST);
   wire word_done = sclk_rise && (state == ECGC_DATA) && (bit_cnt == ECGC_WORD_LAST);

   // Header fields: flag in the first bit, address in the next seven.
   wire head_rw = shreg_shifted[ECGC_HEAD_BITS-1];
   wire [6:0] head_addr = shreg_shifted[ECGC_ADDR_BITS-1:0];
   wire head_hit = (head_addr == ECGC_ADDR_CTL);

   // Only address 0x01 is mapped; reserved bits 18-11 read back as zero.
   wire [23:0] ctl_word = {ctl.left_arm_channel_enable, ctl.left_leg_channel_enable,
                           ctl.right_arm_channel_enable, ctl.chest_one_channel_enable,
                           ctl.chest_two_channel_enable, 8'h00,
                           ctl.differential_input_select, ctl.gain_code, 8'h00};
   wire [23:0] read_word = head_hit ? ctl_word : 24'h000000;

   // Full word: data is the low 24 bits.
   wire [23:0] data_word = shreg_shifted[ECGC_DATA_BITS-1:0];
   wire [6:0] word_addr = shreg_shifted[ECGC_WORD_BITS-2:ECGC_DATA_BITS];
   wire commit = word_done && (rw_flag == ECGC_RW_WRITE) && (word_addr == ECGC_ADDR_CTL);

   // Field extraction for the five enables.
   wire [4:0] new_enable = data_word[ECGC_EN_HI:ECGC_EN_LO];
   wire new_diff = data_word[ECGC_DIFF_BIT];
   // Gain field; code 11 is stored as written and calibration is left to the host.
   wire [1:0] new_gain = data_word[ECGC_GAIN_HI:ECGC_GAIN_LO];

   assign next_ctl = commit ? ecgc_ctrl_t'{left_arm_channel_enable: new_enable[4],
                                left_leg_channel_enable: new_enable[3],
                                right_arm_channel_enable: new_enable[2],
                                chest_one_channel_enable: new_enable[1],
                                chest_two_channel_enable: new_enable[0],
                                differential_input_select: new_diff,
                                gain_code: new_gain} : ctl;
   assign next_ctl_written = commit;

   // Sequencing of a frame. Deselect aborts any partial word, so a short frame writes nothing.
   always_comb begin
      next_state = state;
      unique case (state)
         ECGC_IDLE: begin
            if (selected) begin
               next_state = ECGC_HEAD;
            end
         end
         ECGC_HEAD: begin
            if (!selected) begin
               next_state = ECGC_IDLE;
            end else if (head_done) begin
               next_state = ECGC_DATA;
            end
         end
         ECGC_DATA: begin
            if (!selected) begin
               next_state = ECGC_IDLE;
            end else if (word_done) begin
               next_state = ECGC_DONE;
            end
         end
         ECGC_DONE: begin
            if (!selected) begin
               next_state = ECGC_IDLE;
            end
         end
      endcase
   end

   wire shifting = sclk_rise && ((state == ECGC_HEAD) || (state == ECGC_DATA));

   assign next_shreg = (state == ECGC_IDLE) ? 32'h00000000 : (shifting ? shreg_shifted : shreg);
   assign next_bit_cnt = (state == ECGC_IDLE) ? 6'h00 : (shifting ? bit_cnt + 6'h01 : bit_cnt);
   assign next_rw_flag = head_done ? head_rw : rw_flag;

   // Read data is loaded once the address is known and leaves on the following falling edges.
   wire out_shift = sclk_fall && (state == ECGC_DATA);
   wire read_frame = (rw_flag != ECGC_RW_WRITE);
   assign next_out_shreg = head_done ? read_word :
                           (out_shift ? {out_shreg[22:0], 1'b0} : out_shreg);
   assign next_sdo = !selected ? 1'b0 : ((out_shift && read_frame) ? out_shreg[23] : sdo);
   // The pin is driven through the whole data phase of a read, so writes never contend.
   assign next_sdo_oe = selected && read_frame && ((state == ECGC_DATA) || (state == ECGC_DONE));

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ECGC_IDLE;
         sclk_q <= 1'b0;
         shreg <= 32'h00000000;
         bit_cnt <= 6'h00;
         out_shreg <= 24'h000000;
         rw_flag <= 1'b0;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         state <= next_state;
         sclk_q <= pins_s.sclk;
         shreg <= next_shreg;
         bit_cnt <= next_bit_cnt;
         out_shreg <= next_out_shreg;
         rw_flag <= next_rw_flag;
         sdo <= next_sdo;
         sdo_oe <= next_sdo_oe;
      end
   end

   // Register and all front-end controls except input_high_z clear on reset; input_high_z resets to all ones.
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl <= ECGC_CTRL_RESET;
         ctl_written <= 1'b0;
      end else begin
         ctl <= next_ctl;
         ctl_written <= next_ctl_written;
      end
   end

   // Disabled channels float their inputs; outputs mirror the register through a flop.
   wire [4:0] en_vec = {ctl.left_arm_channel_enable, ctl.left_leg_channel_enable,
                        ctl.right_arm_channel_enable, ctl.chest_one_channel_enable,
                        ctl.chest_two_channel_enable};

   wire [4:0] next_channel_enable;
   wire [4:0] next_input_high_z;

   // Per-channel decode; one flop process keeps each output vector single-driven.
   genvar ch;
   generate
      for (ch = 0; ch < ECGC_CHANNELS; ch++) begin : g_chan
         assign next_channel_enable[ch] = en_vec[ch];
         assign next_input_high_z[ch] = ~en_vec[ch];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         channel_enable <= 5'h00;
         input_high_z <= 5'h1f;
      end else begin
         channel_enable <= next_channel_enable;
         input_high_z <= next_input_high_z;
      end
   end

   // Front-end mode and gain follow the register one cycle later.
   always_ff @(posedge clk) begin
      if (rst) begin
         differential_input_select <= 1'b0;
         gain_code <= ECGC_GAIN_X1P4;
      end else begin
         differential_input_select <= ctl.differential_input_select;
         gain_code <= ctl.gain_code;
      end
   end

endmodule

// >>> verification/ecgc_monitor.sv
// Port checker for the electrode channel control register block.
`timescale 1ns/1ps
module ecgc_monitor (
   input wire logic clk, // System clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic sclk, // Serial clock pin.
   input wire logic cs_n, // Select pin, active low.
   input wire logic sdo, // Serial data out.
   input wire logic sdo_oe, // Device drive enable for sdo.
   input wire logic [4:0] channel_enable, // Channel power enables.
   input wire logic [4:0] input_high_z, // Channel input high-Z requests.
   input wire logic differential_input_select, // Input type select.
   input wire logic [1:0] gain_code, // Front-end gain code.
   input wire logic ctl_written // Update pulse.
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   reset_zero_a: assert property ($fell(rst) |-> channel_enable == 5'h00 && input_high_z == 5'h1f
      && !differential_input_select && gain_code == 2'h0 && !ctl_written && !sdo_oe) else $error("reset values");
   hz_inverse_a: assert property (input_high_z == ~channel_enable) else $error("high_z not inverse");
   field_change_a: assert property ($changed({channel_enable, differential_input_select, gain_code})
      |-> $past(ctl_written)) else $error("control changed without write");
   pulse_once_a: assert property (ctl_written |=> !ctl_written) else $error("write pulse too long");
   oe_release_a: assert property (cs_n [*6] |-> !sdo_oe) else $error("sdo driven outside frame");
   sdo_quiet_a: assert property (!sdo_oe |-> !sdo) else $error("sdo high while released");
   oe_in_frame_a: assert property ($rose(sdo_oe) |-> !cs_n && !$past(cs_n, 4)) else $error("sdo_oe rose");
   sdo_on_fall_a: assert property ($changed(sdo) |-> !$past(sclk, 3)) else $error("sdo moved off fall");
   cover property (ctl_written);
   cover property ($rose(sdo_oe));
   cover property (gain_code == 2'h3 && differential_input_select);
endmodule

// >>> verification/ecgc_host_model.sv
// Behavioural host that sends one serial word per select period.
`timescale 1ns/1ps
module ecgc_host_model (
   input wire logic clk, // System clock, used for bit timing.
   input wire logic sdo, // Serial data from the device.
   input wire logic sdo_oe, // Device drive enable.
   output logic sclk, // Serial clock, still outside frames.
   output logic cs_n, // Select, active low.
   output logic sdi // Serial data to the device.
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // calibration is left to the caller and the bit rate is fixed at ten clk periods per bit; this model only moves words.
   task automatic xfer(input logic [31:0] word, input int nbits, output logic [23:0] rd);
      rd = 24'h000000;
      @(negedge clk);
      cs_n = 1'b0;
      repeat (5) @(negedge clk);
      for (int i = 0; i < nbits; i++) begin
         sdi = word[31-i];
         repeat (5) @(negedge clk);
         if (i >= 8)
            rd[31-i] = sdo_oe ? sdo : 1'bx;
         sclk = 1'b1;
         repeat (5) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (8) @(negedge clk);
      cs_n = 1'b1;
      // A released data line must not keep looking valid.
      sdi = ~sdi;
      repeat (6) @(negedge clk);
   endtask
endmodule

// >>> verification/ecg_channel_control_register_tb.sv
// Self-checking bench for the electrode channel control register block.
`timescale 1ns/1ps
module ecg_channel_control_register_tb;
   import ecgc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk, cs_n, sdi, sdo, sdo_oe, differential_input_select, ctl_written;
   logic [4:0] channel_enable, input_high_z;
   logic [1:0] gain_code;
   int err_total = 0;
   int n_tests = 0;
   int n_writes = 0;
   always #25 clk = ~clk;
   always @(negedge clk) begin
      if (ctl_written !== 1'b0)
         n_writes++;
   end
   ecgc_top dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
      .channel_enable(channel_enable), .input_high_z(input_high_z),
      .differential_input_select(differential_input_select), .gain_code(gain_code), .ctl_written(ctl_written));
   ecgc_host_model host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
   task automatic tally_and_finish();
      if (err_total == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk_rd(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ctl(input logic [23:0] d);
      n_tests++;
      if ({channel_enable, input_high_z, differential_input_select, gain_code} !== {d[23:19], ~d[23:19], d[10], d[9:8]}) begin
         err_total++;
         $display("[FAIL] %0t control outputs do not match %h", $time, d);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         err_total++;
         $display("[FAIL] %0t write pulses %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [23:0] d, input int n);
      logic [23:0] rd;
      host.xfer({ECGC_RW_WRITE, a, d}, n, rd);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [23:0] exp);
      logic [23:0] rd;
      host.xfer({~ECGC_RW_WRITE, a, 24'h5a5a5a}, 32, rd);
      chk_rd(rd, exp);
   endtask
   task automatic t_reset_values();
      @(negedge clk);
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk_ctl(ECGC_CTL_RESET);
      rd_chk(ECGC_ADDR_CTL, 24'h000000);
   endtask
   task automatic t_all_fields();
      wr(ECGC_ADDR_CTL, 24'hf80700, 32);
      chk_ctl(24'hf80700);
      rd_chk(ECGC_ADDR_CTL, 24'hf80700);
   endtask
   task automatic t_each_field();
      logic [23:0] d;
      for (int c = 0; c < 5; c++) begin
         // Gain code 3 comes up at c = 3; calibration afterwards is the host's duty.
         d = (24'h080000 << c) | {13'h0000, c[0], c[1:0], 8'h00};
         wr(ECGC_ADDR_CTL, d, 32);
         chk_ctl(d);
         rd_chk(ECGC_ADDR_CTL, d);
      end
   endtask
   task automatic t_refused();
      int w0;
      wr(ECGC_ADDR_CTL, 24'hf80700, 32);
      w0 = n_writes;
      wr(7'h02, 24'h000000, 32);
      chk_ctl(24'hf80700);
      rd_chk(7'h02, 24'h000000);
      wr(ECGC_ADDR_CTL, 24'h000000, 31);
      chk_ctl(24'hf80700);
      chk_cnt(n_writes, w0);
      wr(ECGC_ADDR_CTL, 24'h7fffff, 32);
      chk_cnt(n_writes, w0 + 1);
      rd_chk(ECGC_ADDR_CTL, 24'h780700);
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end
   initial begin
      t_reset_values();
      t_all_fields();
      t_each_field();
      t_refused();
      t_reset_values();
      tally_and_finish();
   end
endmodule
bind ecgc_top ecgc_monitor mon (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe),
   .channel_enable(channel_enable), .input_high_z(input_high_z),
   .differential_input_select(differential_input_select), .gain_code(gain_code), .ctl_written(ctl_written));
